// File: rtl/jsb_pkg.sv
// Constants, types and field layouts shared by the test-port service bus bridge.
package jsb_pkg;

  // APB register byte offsets.
  localparam logic [7:0] JSB_CTRL_OFS = 8'h00;
  localparam logic [7:0] JSB_STATUS_OFS = 8'h04;
  localparam logic [7:0] JSB_ADDR_LO_OFS = 8'h08;
  localparam logic [7:0] JSB_ADDR_HI_OFS = 8'h0C;
  localparam logic [7:0] JSB_RDATA_OFS = 8'h10;

  // Control register fields and reset value.
  localparam int JSB_CTRL_EN_BIT = 0;
  localparam logic [31:0] JSB_CTRL_RST = 32'h0000_0001;

  // Status register field positions.
  localparam int JSB_ST_BUSY_BIT = 0;
  localparam int JSB_ST_ERR_BIT = 1;
  localparam int JSB_ST_DPHASE_BIT = 2;
  localparam int JSB_ST_SYNC_BIT = 3;
  localparam int JSB_ST_SECURE_BIT = 4;

  // Instruction codes of the 5-bit instruction register.
  localparam logic [4:0] JSB_OP_IDCODE = 5'h01;
  localparam logic [4:0] JSB_OP_DEBUG = 5'h10;
  localparam logic [4:0] JSB_OP_WORD = 5'h11;
  localparam logic [4:0] JSB_OP_BLOCK = 5'h12;
  localparam logic [4:0] JSB_OP_CANCEL = 5'h13;
  localparam logic [4:0] JSB_OP_SIZED = 5'h15;
  localparam logic [4:0] JSB_OP_SYNC = 5'h17;
  localparam logic [4:0] JSB_IR_RST = JSB_OP_IDCODE;

  // Scan chain lengths and field positions, least significant bit shifted first.
  localparam int JSB_IR_LEN = 5;
  localparam int JSB_ADDR_LEN = 41;
  localparam int JSB_DATA_LEN = 34;
  localparam int JSB_ID_LEN = 32;
  localparam int JSB_SR_W = 41;
  localparam int JSB_F_BUSY = 0;
  localparam int JSB_F_ERR = 1;
  localparam int JSB_F_ADDR = 2;
  localparam int JSB_F_DATA = 2;
  localparam int JSB_F_SIZE = 38;
  localparam int JSB_F_READ = 40;
  localparam int JSB_SYNC_W = 16;

  // Transfer size codes.
  localparam logic [1:0] JSB_SZ_BYTE = 2'h0;
  localparam logic [1:0] JSB_SZ_HALF = 2'h1;
  localparam logic [1:0] JSB_SZ_WORD = 2'h2;

  // Debug registers live in a 7-bit word index space above this base.
  localparam logic [35:0] JSB_DBG_BASE = 36'h0_0000_0000;

  typedef enum logic [3:0] {
    JSB_RESET, JSB_IDLE, JSB_SEL_DR, JSB_CAP_DR, JSB_SH_DR, JSB_EX1_DR, JSB_PA_DR,
    JSB_EX2_DR, JSB_UPD_DR, JSB_SEL_IR, JSB_CAP_IR, JSB_SH_IR, JSB_EX1_IR, JSB_PA_IR,
    JSB_EX2_IR, JSB_UPD_IR
  } jsb_tap_e;

  // One service bus request.
  typedef struct packed {
    logic write;
    logic [1:0] size;
    logic [35:0] addr;
    logic [31:0] wdata;
  } jsb_sb_req_s;

endpackage

// File: rtl/jsb_top.sv
// Test access port bridge that masters the on-chip service bus.
//
// Added by the designer: the APB interface to the registers and the register offsets.
module jsb_top import jsb_pkg::*; #(
  parameter logic [31:0] ID_VALUE = 32'h0000_0001,
  parameter logic [35:0] USER_PAGE_BASE = 36'h0_8080_0000,
  parameter logic [35:0] USER_PAGE_MASK = 36'hF_FFFF_FE00,
  parameter logic [35:0] MSU_BASE = 36'h1_0000_0000,
  parameter logic [35:0] MSU_MASK = 36'hF_FFFF_F000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Test access port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Service bus master
  output jsb_sb_req_s sb_req,
  output logic sb_valid,
  output logic sb_cancel,
  input wire logic sb_ack,
  input wire logic sb_err,
  input wire logic [31:0] sb_rdata,
  // System
  input wire logic secure_fuse,
  output logic clk_wake
);

  logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2;
  logic tck_rise, tck_fall;
  jsb_tap_e tap_reg, tap_next;
  logic [4:0] ir_sr_reg, ir_reg;
  logic [JSB_SR_W-1:0] dr_sr_reg;
  logic busy_reg, error_reg, dphase_reg, last_read_reg, drained_reg, cap_busy_reg;
  logic sync_run_reg, en_reg;
  logic [JSB_SYNC_W-1:0] sync_cnt_reg;
  logic [35:0] addr_reg;
  logic [1:0] size_reg;
  logic [31:0] rdata_reg;
  logic upd_dr, upd_ir, cap_dr, is_two, is_block, two_rd;
  logic [35:0] dr_addr, blk_addr;
  logic [1:0] dr_size;
  logic [31:0] dr_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tck_s1, tck_s2, tck_s3} <= 3'h0;
      {tms_s1, tms_s2, tdi_s1, tdi_s2} <= 4'h0;
    end else begin
      tck_s1 <= tck;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tms_s1 <= tms;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi;
      tdi_s2 <= tdi_s1;
    end
  end

  assign tck_rise = tck_s2 & ~tck_s3;
  assign tck_fall = ~tck_s2 & tck_s3;

  // restart request on any test clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_wake <= 1'b0;
    end else begin
      clk_wake <= tck_rise | tck_fall;
    end
  end

  always_comb begin
    tap_next = tap_reg;
    unique case (tap_reg)
      JSB_RESET: tap_next = tms_s2 ? JSB_RESET : JSB_IDLE;
      JSB_IDLE: tap_next = tms_s2 ? JSB_SEL_DR : JSB_IDLE;
      JSB_SEL_DR: tap_next = tms_s2 ? JSB_SEL_IR : JSB_CAP_DR;
      JSB_CAP_DR: tap_next = tms_s2 ? JSB_EX1_DR : JSB_SH_DR;
      JSB_SH_DR: tap_next = tms_s2 ? JSB_EX1_DR : JSB_SH_DR;
      JSB_EX1_DR: tap_next = tms_s2 ? JSB_UPD_DR : JSB_PA_DR;
      JSB_PA_DR: tap_next = tms_s2 ? JSB_EX2_DR : JSB_PA_DR;
      JSB_EX2_DR: tap_next = tms_s2 ? JSB_UPD_DR : JSB_SH_DR;
      JSB_UPD_DR: tap_next = tms_s2 ? JSB_SEL_DR : JSB_IDLE;
      JSB_SEL_IR: tap_next = tms_s2 ? JSB_RESET : JSB_CAP_IR;
      JSB_CAP_IR: tap_next = tms_s2 ? JSB_EX1_IR : JSB_SH_IR;
      JSB_SH_IR: tap_next = tms_s2 ? JSB_EX1_IR : JSB_SH_IR;
      JSB_EX1_IR: tap_next = tms_s2 ? JSB_UPD_IR : JSB_PA_IR;
      JSB_PA_IR: tap_next = tms_s2 ? JSB_EX2_IR : JSB_PA_IR;
      JSB_EX2_IR: tap_next = tms_s2 ? JSB_UPD_IR : JSB_SH_IR;
      JSB_UPD_IR: tap_next = tms_s2 ? JSB_SEL_DR : JSB_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_reg <= JSB_RESET;
    end else if (tck_rise) begin
      tap_reg <= tap_next;
    end
  end

  assign upd_dr = tck_rise & (tap_next == JSB_UPD_DR);
  assign upd_ir = tck_rise & (tap_next == JSB_UPD_IR);
  assign cap_dr = tck_rise & (tap_next == JSB_CAP_DR);
  assign is_two = (ir_reg == JSB_OP_SIZED) | (ir_reg == JSB_OP_WORD) |
                  (ir_reg == JSB_OP_DEBUG);
  assign is_block = ir_reg == JSB_OP_BLOCK;

  // decode of the 41-bit address pass
  always_comb begin
    dr_size = JSB_SZ_WORD;
    dr_addr = dr_sr_reg[JSB_F_ADDR +: 36];
    if (ir_reg == JSB_OP_SIZED) begin
      dr_size = dr_sr_reg[JSB_F_SIZE +: 2];
    end else if (ir_reg == JSB_OP_DEBUG) begin
      dr_addr = JSB_DBG_BASE | {27'h0, dr_sr_reg[JSB_F_ADDR +: 7], 2'h0};
    end
  end

  assign two_rd = dr_sr_reg[JSB_F_READ];
  assign dr_data = dr_sr_reg[JSB_F_DATA +: 32];
  // next block address advances by the last transfer size
  assign blk_addr = addr_reg + (36'h1 << size_reg);

  // accesses refused before reaching the bus
  function automatic logic jsb_deny(input logic [35:0] a, input logic [1:0] sz,
                                    input logic sec);
    logic bad;
    bad = (sz == 2'h3) | ((sz == JSB_SZ_HALF) & a[0]) | ((sz == JSB_SZ_WORD) & |a[1:0]);
    if (sec && ((a & USER_PAGE_MASK) != USER_PAGE_BASE) && ((a & MSU_MASK) != MSU_BASE)) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  // instruction register, captured status shows busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_sr_reg <= 5'h00;
      ir_reg <= JSB_IR_RST;
    end else if (tck_rise) begin
      if (tap_next == JSB_RESET) begin
        ir_reg <= JSB_IR_RST;
      end else if (tap_next == JSB_CAP_IR) begin
        ir_sr_reg <= {1'b0, error_reg, busy_reg, 2'h1};
      end else if (tap_reg == JSB_SH_IR) begin
        ir_sr_reg <= {tdi_s2, ir_sr_reg[4:1]};
      end else if (tap_next == JSB_UPD_IR) begin
        ir_reg <= ir_sr_reg;
      end
    end
  end

  // data register capture and LSB-first shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dr_sr_reg <= '0;
      cap_busy_reg <= 1'b0;
    end else if (tck_rise) begin
      if (tap_next == JSB_CAP_DR) begin
        cap_busy_reg <= busy_reg;
        dr_sr_reg <= '0;
        if (ir_reg == JSB_OP_IDCODE) begin
          dr_sr_reg[JSB_ID_LEN-1:0] <= ID_VALUE;
        end else begin
          dr_sr_reg[JSB_F_BUSY] <= busy_reg;
          dr_sr_reg[JSB_F_ERR] <= error_reg;
          dr_sr_reg[JSB_F_DATA +: 32] <= rdata_reg;
        end
      end else if (tap_reg == JSB_SH_DR) begin
        dr_sr_reg <= dr_sr_reg >> 1;
        if (ir_reg == JSB_OP_IDCODE) begin
          dr_sr_reg[JSB_ID_LEN-1] <= tdi_s2;
        end else if (is_two && !dphase_reg) begin
          dr_sr_reg[JSB_ADDR_LEN-1] <= tdi_s2;
        end else if (is_two || is_block || ir_reg == JSB_OP_SYNC || ir_reg == JSB_OP_CANCEL) begin
          dr_sr_reg[JSB_DATA_LEN-1] <= tdi_s2;
        end else begin
          dr_sr_reg[0] <= tdi_s2;
        end
      end
    end
  end

  // output changes on falling test clock, enabled only while shifting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= (tap_reg == JSB_SH_IR) ? ir_sr_reg[0] : dr_sr_reg[0];
      tdo_oe <= (tap_reg == JSB_SH_IR) | (tap_reg == JSB_SH_DR);
    end
  end

  // Bus engine: every request from the scan side is judged here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      error_reg <= 1'b0;
      dphase_reg <= 1'b0;
      last_read_reg <= 1'b0;
      drained_reg <= 1'b0;
      sync_run_reg <= 1'b0;
      sync_cnt_reg <= '0;
      addr_reg <= '0;
      size_reg <= JSB_SZ_WORD;
      rdata_reg <= 32'h0000_0000;
      sb_req <= '0;
      sb_valid <= 1'b0;
      sb_cancel <= 1'b0;
    end else begin
      sb_cancel <= 1'b0;
      // completion clears busy; error taken at finish
      if (sb_valid && sb_ack) begin
        sb_valid <= 1'b0;
        busy_reg <= 1'b0;
        error_reg <= sb_err;
        if (!sb_req.write) begin
          rdata_reg <= sb_rdata;
        end
      end
      if (sync_run_reg) begin
        if (sync_cnt_reg == '0) begin
          sync_run_reg <= 1'b0;
          busy_reg <= 1'b0;
        end else begin
          sync_cnt_reg <= sync_cnt_reg - 1'b1;
        end
      end
      // cancel aborts and reports the access as cancelled
      if (upd_ir && ir_sr_reg == JSB_OP_CANCEL) begin
        if (busy_reg) begin
          sb_valid <= 1'b0;
          sb_cancel <= sb_valid;
          sync_run_reg <= 1'b0;
          busy_reg <= 1'b0;
          error_reg <= 1'b1;
        end
        dphase_reg <= 1'b0;
      end else if (upd_ir && ir_sr_reg == JSB_OP_BLOCK && !busy_reg && en_reg) begin
        // prefetch the next read when the last read was drained
        if (last_read_reg && drained_reg) begin
          drained_reg <= 1'b0;
          addr_reg <= blk_addr;
          if (jsb_deny(blk_addr, size_reg, secure_fuse)) begin
            error_reg <= 1'b1;
          end else begin
            sb_req <= '{write: 1'b0, size: size_reg, addr: blk_addr, wdata: 32'h0000_0000};
            sb_valid <= 1'b1;
            busy_reg <= 1'b1;
            error_reg <= 1'b0;
          end
        end
      // requests seen or made while busy are discarded
      end else if (upd_dr && !busy_reg && !cap_busy_reg && en_reg) begin
        if (is_two && !dphase_reg) begin
          // address pass; a read starts at once
          addr_reg <= dr_addr;
          size_reg <= dr_size;
          last_read_reg <= two_rd;
          drained_reg <= 1'b0;
          dphase_reg <= 1'b1;
          if (two_rd) begin
            if (jsb_deny(dr_addr, dr_size, secure_fuse)) begin
              error_reg <= 1'b1;
            end else begin
              sb_req <= '{write: 1'b0, size: dr_size, addr: dr_addr, wdata: 32'h0000_0000};
              sb_valid <= 1'b1;
              busy_reg <= 1'b1;
              error_reg <= 1'b0;
            end
          end
        end else if (is_two) begin
          // data pass ends the two-pass access
          dphase_reg <= 1'b0;
          if (last_read_reg) begin
            drained_reg <= 1'b1;
          end else if (jsb_deny(addr_reg, size_reg, secure_fuse)) begin
            error_reg <= 1'b1;
          end else begin
            sb_req <= '{write: 1'b1, size: size_reg, addr: addr_reg, wdata: dr_data};
            sb_valid <= 1'b1;
            busy_reg <= 1'b1;
            error_reg <= 1'b0;
          end
        end else if (is_block) begin
          // one data pass per transfer at the next address
          addr_reg <= blk_addr;
          drained_reg <= 1'b0;
          if (jsb_deny(blk_addr, size_reg, secure_fuse)) begin
            error_reg <= 1'b1;
          end else begin
            sb_req <= '{write: !last_read_reg, size: size_reg, addr: blk_addr, wdata: dr_data};
            sb_valid <= 1'b1;
            busy_reg <= 1'b1;
            error_reg <= 1'b0;
          end
        end else if (ir_reg == JSB_OP_SYNC) begin
          // counter value loaded starts the countdown
          sync_cnt_reg <= dr_sr_reg[JSB_F_DATA +: JSB_SYNC_W];
          sync_run_reg <= 1'b1;
          busy_reg <= 1'b1;
        end
      end
    end
  end

  // APB slave: one wait state, answer registered so outputs come from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      en_reg <= JSB_CTRL_RST[JSB_CTRL_EN_BIT];
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= 32'h0000_0000;
        unique case (paddr)
          JSB_CTRL_OFS: prdata[JSB_CTRL_EN_BIT] <= en_reg;
          JSB_STATUS_OFS: begin
            prdata[JSB_ST_BUSY_BIT] <= busy_reg;
            prdata[JSB_ST_ERR_BIT] <= error_reg;
            prdata[JSB_ST_DPHASE_BIT] <= dphase_reg;
            prdata[JSB_ST_SYNC_BIT] <= sync_run_reg;
            prdata[JSB_ST_SECURE_BIT] <= secure_fuse;
          end
          JSB_ADDR_LO_OFS: prdata <= addr_reg[31:0];
          JSB_ADDR_HI_OFS: prdata[3:0] <= addr_reg[35:32];
          JSB_RDATA_OFS: prdata <= rdata_reg;
          default: pslverr <= 1'b1;
        endcase
      end
      // Writes land only at the edge where the completed access is sampled.
      if (psel && penable && pready && pwrite && paddr == JSB_CTRL_OFS) begin
        en_reg <= pwdata[JSB_CTRL_EN_BIT];
      end
    end
  end

endmodule

// File: tb/jsb_monitor.sv
// Port-level assertions for the test-port service bus bridge.
module jsb_monitor import jsb_pkg::*; #(
  parameter logic [35:0] USER_PAGE_BASE = 36'h0_8080_0000,
  parameter logic [35:0] USER_PAGE_MASK = 36'hF_FFFF_FE00,
  parameter logic [35:0] MSU_BASE = 36'h1_0000_0000,
  parameter logic [35:0] MSU_MASK = 36'hF_FFFF_F000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Link and service bus
  input wire logic tck,
  input wire jsb_sb_req_s sb_req,
  input wire logic sb_valid,
  input wire logic sb_cancel,
  input wire logic sb_ack,
  input wire logic secure_fuse,
  input wire logic clk_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {JSB_CTRL_OFS, JSB_STATUS_OFS, JSB_ADDR_LO_OFS,
    JSB_ADDR_HI_OFS, JSB_RDATA_OFS};

  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered in one cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_req_hold: assert property (
    sb_valid && !sb_ack |=> sb_cancel || (sb_valid && $stable(sb_req)))
    else $error("bus request changed while outstanding");
  a_ack_release: assert property (sb_valid && sb_ack |=> !sb_valid)
    else $error("bus request not released after ack");
  a_req_align: assert property (
    sb_valid |-> sb_req.size <= JSB_SZ_WORD &&
    (sb_req.addr[1:0] & ~(2'h3 << sb_req.size)) == 2'h0)
    else $error("misaligned or bad sized bus request");
  a_secure_window: assert property (
    $rose(sb_valid) && secure_fuse |-> ((sb_req.addr & USER_PAGE_MASK) == USER_PAGE_BASE) ||
    ((sb_req.addr & MSU_MASK) == MSU_BASE))
    else $error("secure mode request outside allowed windows");
  a_cancel_drop: assert property (sb_cancel |-> !sb_valid && $past(sb_valid))
    else $error("cancel pulse without a dropped request");
  a_wake_follow: assert property ($changed(tck) |-> ##[1:6] clk_wake)
    else $error("test clock edge gave no wake request");

  c_bus_done: cover property (sb_valid && sb_ack);
  c_cancel: cover property (sb_cancel);
  c_unmapped: cover property (pready && pslverr);
endmodule

bind jsb_top jsb_monitor #(
  .USER_PAGE_BASE(USER_PAGE_BASE),
  .USER_PAGE_MASK(USER_PAGE_MASK),
  .MSU_BASE(MSU_BASE),
  .MSU_MASK(MSU_MASK)
) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .tck(tck), .sb_req(sb_req), .sb_valid(sb_valid),
  .sb_cancel(sb_cancel), .sb_ack(sb_ack), .secure_fuse(secure_fuse), .clk_wake(clk_wake)
);

// File: tb/jsb_jtag_master.sv
// Behavioural external test-port master that drives scans.
module jsb_jtag_master (
  // Clock
  input wire logic pclk,
  // Test port
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock period of 8 system cycles; tdo is taken just before the fall.
  task automatic tick(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge pclk);
    tck <= 1'b1;
    repeat (4) @(posedge pclk);
    q = tdo;
    tck <= 1'b0;
  endtask

  task automatic reset_tap();
    logic q;
    repeat (5) tick(1'b1, tdi, q);
    tick(1'b0, tdi, q);
  endtask

  // LSB first shift. The idle data line shows the inverse of the last bit.
  task automatic scan(input logic ir, input int n, input logic [40:0] din,
                      output logic [40:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, tdi, q);
    if (ir) tick(1'b1, tdi, q);
    tick(1'b0, tdi, q);
    tick(1'b0, tdi, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, ~din[n-1], q);
    tick(1'b0, ~din[n-1], q);
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the test-port service bus bridge.
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  import jsb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identification value.
  localparam logic [31:0] ID_VAL = 32'h1234_5671;
  // Instruction code that the bridge does not decode; loading it starts no access.
  localparam logic [4:0] HALT_OP = 5'h1C;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tck, tms, tdi, tdo, tdo_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, sb_rdata, rd;
  logic sb_valid, sb_cancel, sb_ack, sb_err, secure_fuse, clk_wake, rerr, last_v;
  logic [40:0] so;
  logic [35:0] b;
  jsb_sb_req_s sb_req, last_req;
  int bad_count, cmp_count, slow, vcount, ccount, wait_cnt, n0;

  jsb_top #(.ID_VALUE(ID_VAL)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .sb_req(sb_req),
    .sb_valid(sb_valid), .sb_cancel(sb_cancel), .sb_ack(sb_ack), .sb_err(sb_err),
    .sb_rdata(sb_rdata), .secure_fuse(secure_fuse), .clk_wake(clk_wake));
  jsb_jtag_master jm_u (.pclk(pclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Bus slave: slow answers, error for top nibble E; data lines churn when idle.
  always @(posedge pclk) begin
    sb_ack <= 1'b0;
    sb_rdata <= ~sb_rdata;
    if (sb_valid && !sb_ack && wait_cnt >= slow) begin
      sb_ack <= 1'b1;
      sb_err <= sb_req.addr[35:32] == 4'hE;
      sb_rdata <= sb_req.addr[31:0] ^ 32'h5A5A_5A5A;
      last_req <= sb_req;
      wait_cnt <= 0;
    end else wait_cnt <= sb_valid ? wait_cnt + 1 : 0;
    if (sb_valid && !last_v) vcount <= vcount + 1;
    if (sb_cancel) ccount <= ccount + 1;
    last_v <= sb_valid;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Nothing but the bench timeout bounds this poll, so a hang still reaches the verdict as a failure.
  task automatic idle_wait();
    do begin
      apb(1'b0, JSB_STATUS_OFS, 32'h0);
    end while (rd[JSB_ST_BUSY_BIT] !== 1'b0);
  endtask

  task automatic ir(input logic [4:0] op);
    jm_u.scan(1'b1, JSB_IR_LEN, {36'h0, op}, so);
  endtask

  task automatic dr(input int n, input logic [40:0] d);
    jm_u.scan(1'b0, n, d, so);
  endtask

  function automatic logic [40:0] ap(input logic r, input logic [1:0] z, input logic [35:0] a);
    return {r, z, a, 2'b00};
  endfunction

  function automatic logic [31:0] f(input logic [35:0] a);
    return a[31:0] ^ 32'h5A5A_5A5A;
  endfunction

  // Cancel first so that each access starts from the address phase.
  task automatic acc(input logic [4:0] op, input logic r, input logic [1:0] z,
                     input logic [35:0] a);
    ir(JSB_OP_CANCEL);
    ir(op);
    dr(JSB_ADDR_LEN, ap(r, z, a));
    idle_wait();
  endtask

  initial begin
    repeat (90000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, secure_fuse, sb_ack, sb_err, last_v} = '0;
    {sb_rdata, presetn, slow, vcount, ccount, wait_cnt, bad_count, cmp_count} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, JSB_CTRL_OFS, 32'h0);
    `CHK("ctrl_reset", JSB_CTRL_RST, rd)
    apb(1'b0, JSB_STATUS_OFS, 32'h0);
    `CHK("status_reset", 32'h0, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, rerr)
    jm_u.reset_tap();
    dr(JSB_ID_LEN, 41'h0);
    `CHK("idcode", ID_VAL, so[31:0])
    `CHK("tdo_idle", 1'b0, tdo_oe)
    b = 36'h3_1234_5678;
    apb(1'b1, JSB_CTRL_OFS, 32'h0000_0000);
    apb(1'b0, JSB_CTRL_OFS, 32'h0);
    `CHK("ctrl_wr", 32'h0, rd)
    n0 = vcount;
    acc(JSB_OP_WORD, 1'b1, JSB_SZ_WORD, b);
    `CHK("dis_req", n0, vcount)
    apb(1'b1, JSB_CTRL_OFS, 32'h0000_0001);
    acc(JSB_OP_WORD, 1'b1, JSB_SZ_WORD, b);
    `CHK("word_size", JSB_SZ_WORD, last_req.size)
    dr(JSB_DATA_LEN, 41'h0);
    `CHK("word_rd", f(b), so[33:2])
    apb(1'b0, JSB_RDATA_OFS, 32'h0);
    `CHK("rdata_reg", f(b), rd)
    ir(JSB_OP_BLOCK);
    idle_wait();
    for (int k = 1; k <= 2; k++) begin
      dr(JSB_DATA_LEN, 41'h0);
      `CHK("blk_rd", f(b + 36'(4 * k)), so[33:2])
      idle_wait();
    end
    apb(1'b0, JSB_ADDR_LO_OFS, 32'h0);
    `CHK("blk_addr", b[31:0] + 32'h0000_000C, rd)
    apb(1'b0, JSB_ADDR_HI_OFS, 32'h0);
    `CHK("blk_addr_hi", {28'h0, b[35:32]}, rd)
    acc(JSB_OP_DEBUG, 1'b1, JSB_SZ_BYTE, 36'hF_FFFF_FFFF);
    `CHK("dbg_addr", JSB_DBG_BASE + 36'h0_0000_01FC, last_req.addr)
    dr(JSB_DATA_LEN, 41'h0);
    ir(HALT_OP);
    for (int z = 0; z < 3; z++) begin
      acc(JSB_OP_SIZED, 1'b0, 2'(z), 36'h2_0000_0010);
      dr(JSB_DATA_LEN, {7'h0, 32'hC0DE_0000 + 32'(z), 2'b00});
      idle_wait();
      `CHK("wr_size", 2'(z), last_req.size)
      `CHK("wr_data", 32'hC0DE_0000 + 32'(z), last_req.wdata)
    end
    n0 = vcount;
    acc(JSB_OP_SIZED, 1'b1, JSB_SZ_HALF, 36'h2_0000_0011);
    `CHK("misalign_req", n0, vcount)
    `CHK("misalign_err", 1'b1, rd[JSB_ST_ERR_BIT])
    acc(JSB_OP_WORD, 1'b1, JSB_SZ_WORD, 36'hE_0000_0000);
    dr(JSB_DATA_LEN, 41'h0);
    `CHK("err_scan", 1'b1, so[1])
    n0 = vcount;
    dr(JSB_ADDR_LEN, ap(1'b1, JSB_SZ_WORD, b));
    idle_wait();
    `CHK("err_addr_taken", n0 + 1, vcount)
    `CHK("err_cleared", 1'b0, rd[JSB_ST_ERR_BIT])
    dr(JSB_DATA_LEN, 41'h0);
    slow = 5000;
    n0 = ccount;
    dr(JSB_ADDR_LEN, ap(1'b1, JSB_SZ_WORD, b));
    dr(JSB_DATA_LEN, 41'h0);
    `CHK("busy_rd", 1'b1, so[0])
    ir(JSB_OP_CANCEL);
    `CHK("ir_busy", 1'b1, so[2])
    `CHK("cancel_pulse", n0 + 1, ccount)
    dr(JSB_DATA_LEN, 41'h0);
    `CHK("cancel_flags", 2'b10, so[1:0])
    slow = 0;
    ir(JSB_OP_SYNC);
    dr(JSB_DATA_LEN, {23'h0, 16'h00C8, 2'b00});
    apb(1'b0, JSB_STATUS_OFS, 32'h0);
    `CHK("sync_busy", 1'b1, rd[JSB_ST_SYNC_BIT] & rd[JSB_ST_BUSY_BIT])
    idle_wait();
    `CHK("sync_done", 1'b0, rd[JSB_ST_SYNC_BIT])
    // A long countdown keeps the bridge busy across a whole address scan.
    dr(JSB_DATA_LEN, {23'h0, 16'h0400, 2'b00});
    ir(JSB_OP_WORD);
    `CHK("ir_busy_word", 1'b1, so[2])
    n0 = vcount;
    dr(JSB_ADDR_LEN, ap(1'b1, JSB_SZ_WORD, b));
    `CHK("addr_busy", 1'b1, so[0])
    idle_wait();
    `CHK("addr_dropped", n0, vcount)
    `CHK("addr_phase", 1'b0, rd[JSB_ST_DPHASE_BIT])
    acc(JSB_OP_WORD, 1'b0, JSB_SZ_WORD, 36'h2_0000_0020);
    ir(JSB_OP_SYNC);
    dr(JSB_DATA_LEN, {23'h0, 16'h0400, 2'b00});
    ir(JSB_OP_WORD);
    n0 = vcount;
    dr(JSB_DATA_LEN, {7'h0, 32'hBEEF_0001, 2'b00});
    `CHK("wr_busy", 1'b1, so[0])
    idle_wait();
    `CHK("wr_dropped", n0, vcount)
    dr(JSB_DATA_LEN, {7'h0, 32'hBEEF_0002, 2'b00});
    idle_wait();
    `CHK("wr_retry", 32'hBEEF_0002, last_req.wdata)
    secure_fuse <= 1'b1;
    n0 = vcount;
    acc(JSB_OP_WORD, 1'b1, JSB_SZ_WORD, b);
    `CHK("sec_block", n0, vcount)
    `CHK("sec_err", 1'b1, rd[JSB_ST_ERR_BIT] & rd[JSB_ST_SECURE_BIT])
    acc(JSB_OP_WORD, 1'b1, JSB_SZ_WORD, 36'h0_8080_0010);
    dr(JSB_DATA_LEN, 41'h0);
    `CHK("sec_page_rd", f(36'h0_8080_0010), so[33:2])
    secure_fuse <= 1'b0;
    tally_and_finish();
  end
endmodule
